// ### rtl/mbpc_device.sv
// Functional notes
// RULE1: select 0: shared pin fall enters fail-safe
// RULE2: fail-safe function: enable bit edges switch phase
// RULE3: select 1 outside fail-safe: phase runs on bit and pin
// RULE4: enable bit 0 forces phase and gate off
// RULE5: host zeroes amp gain when all off
// RULE6: host inverts sync edge on slave only; roles 00 and 11 pass ctrl bit CTRL_INV instead
// RULE7: host sets gain 00 on slaves
// RULE8: role 01 drives comp, 10 senses
// RULE9: five-bit share sets divider 4 to 20
// RULE10: signed share code gives divider ratio
// RULE11: same divider scales slope ramp
// RULE12: own overvoltage sensing stops own gates
// RULE13: host programs equal overvoltage thresholds
// RULE14: invert 0 rising edge, 1 falling
// RULE15: sync sampled, edges debounced two cycles
// RULE16: 32-entry share lookup for each phase
//
// Design decisions made here: the placing of the registers and the APB slave port.
module mbpc_device
  import mbpc_pkg::*;
(
  input  wire logic                                      MCLK,
  input  wire logic                                      NRST,
  mbpc_if.dev                                            LINK,
  input  wire logic [mbpc_pkg::PHASES-1:0]               ENABLE_PIN,
  input  wire logic                                      SYNC_IN,
  input  wire logic [mbpc_pkg::PHASES-1:0]               PEAK_TRIP,
  input  wire logic [mbpc_pkg::OV_W-1:0]                 OV_SENSE,
  output logic      [mbpc_pkg::PHASES-1:0]               GATE,
  output logic      [mbpc_pkg::PHASES-1:0][mbpc_pkg::DIV_W-1:0] PEAK_DIV,
  output logic      [mbpc_pkg::PHASES-1:0][mbpc_pkg::DIV_W-1:0] SLOPE_DIV,
  output logic      [1:0]                                AMP_GAIN,
  output logic                                           AMP_EN,
  output logic                                           COMP_DRIVE_EN,
  output logic                                           COMP_SENSE_ONLY,
  output logic                                           FAIL_SAFE
);
  import mbpc_pkg::*;

  // ***********************************************************
  // lookup
  // ***********************************************************
  function automatic logic [DIV_W-1:0] share_div(
    input logic [SHARE_W-1:0] code
  );
    share_div = DIV_TABLE[code];
  endfunction : share_div

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  logic                            sel_q;
  logic [PHASES-1:0]               en_q;
  logic [PHASES-1:0]               en_prev_q;
  logic                            inv_q;
  logic [1:0]                      gain_q;
  logic [1:0]                      role_q;
  logic [PHASES-1:0][SHARE_W-1:0]  share_q;
  logic [OV_W-1:0]                 ovthr_q;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sel_q     <= 1'b0;
      en_q      <= '0;
      en_prev_q <= '0;
      inv_q     <= 1'b0;
      gain_q    <= GAIN_OFF;
      role_q    <= 2'h0;
      share_q   <= '0;
      ovthr_q   <= RST_OVTHR;
    end
    else
    begin
      sel_q     <= LINK.pin_function_select;
      en_q      <= LINK.phase_enable_bit;
      en_prev_q <= en_q;
      inv_q     <= LINK.sync_edge_invert;
      gain_q    <= LINK.error_amp_gain;
      role_q    <= LINK.multiphase_role;
      share_q   <= LINK.phase_power_share;
      ovthr_q   <= LINK.ov_threshold;
    end
  end

  // ***********************************************************
  // pin synchronisers and debounce
  // ***********************************************************
  logic [PIN_CNT-1:0] pins;
  logic [PIN_CNT-1:0] s1_q;
  logic [PIN_CNT-1:0] s2_q;
  logic [PIN_CNT-1:0] s3_q;
  logic [PIN_CNT-1:0] db_q;
  logic [PIN_CNT-1:0] db_prev_q;

  assign pins = {PEAK_TRIP, SYNC_IN, ENABLE_PIN};

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      db_q      <= '0;
      db_prev_q <= '0;
    end
    else
    begin
      s1_q      <= pins;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      for (int i = 0; i < PIN_CNT; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          db_q[i] <= s3_q[i]; // RULE15
        end
      end
      db_prev_q <= db_q;
    end
  end

  logic sync_rise;
  logic sync_fall;
  logic sync_evt;
  logic shared_fall;

  assign sync_rise   = db_q[PIN_SYNC] & ~db_prev_q[PIN_SYNC];
  assign sync_fall   = ~db_q[PIN_SYNC] & db_prev_q[PIN_SYNC];
  assign sync_evt    = inv_q ? sync_fall : sync_rise; // RULE14
  assign shared_fall = ~db_q[PIN_SHARED] & db_prev_q[PIN_SHARED];

  // ***********************************************************
  // fail-safe mode
  // ***********************************************************
  mbpc_mode_t mode_q;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      mode_q <= MD_NORMAL;
    end
    else
    begin
      case (mode_q)
        MD_NORMAL:
        begin
          if (!sel_q && shared_fall)
          begin
            mode_q <= MD_FAILSAFE; // RULE1
          end
        end
        MD_FAILSAFE:
        begin
          mode_q <= MD_FAILSAFE;
        end
        default:
        begin
          mode_q <= MD_NORMAL;
        end
      endcase
    end
  end

  // ***********************************************************
  // phase enable
  // ***********************************************************
  logic [PHASES-1:0] req_q;
  logic [PHASES-1:0] run;
  logic [PHASES-1:0] pin_en;

  assign pin_en = db_q[PHASES-1:0];

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      req_q <= '0;
    end
    else
    begin
      for (int i = 0; i < PHASES; i++)
      begin
        if (en_q[i] && !en_prev_q[i])
        begin
          req_q[i] <= 1'b1; // RULE2
        end
        else if (!en_q[i] && en_prev_q[i])
        begin
          req_q[i] <= 1'b0; // RULE2
        end
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < PHASES; i++)
    begin
      if (!en_q[i])
      begin
        run[i] = 1'b0; // RULE4
      end
      else if (sel_q && mode_q == MD_NORMAL)
      begin
        run[i] = pin_en[i]; // RULE3
      end
      else
      begin
        run[i] = req_q[i]; // RULE2
      end
    end
  end

  // ***********************************************************
  // overvoltage and gate drive
  // ***********************************************************
  logic              ov_q;
  logic [PHASES-1:0] gate_q;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ov_q <= 1'b0;
    end
    else
    begin
      ov_q <= (OV_SENSE > ovthr_q); // RULE12
    end
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      gate_q <= '0;
    end
    else
    begin
      for (int i = 0; i < PHASES; i++)
      begin
        if (!run[i] || ov_q)
        begin
          gate_q[i] <= 1'b0; // RULE4 RULE12
        end
        else if (sync_evt)
        begin
          gate_q[i] <= 1'b1; // RULE14
        end
        else if (db_q[PIN_TRIP0 + i])
        begin
          gate_q[i] <= 1'b0;
        end
      end
    end
  end

  // ***********************************************************
  // power share dividers
  // ***********************************************************
  logic [PHASES-1:0][DIV_W-1:0] div_q;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      div_q <= '0;
    end
    else
    begin
      for (int i = 0; i < PHASES; i++)
      begin
        div_q[i] <= share_div(share_q[i]); // RULE9 RULE10 RULE16
      end
    end
  end

  // ***********************************************************
  // amplifier role and outputs
  // ***********************************************************
  logic drive_q;
  logic sense_q;
  logic amp_en_q;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      drive_q  <= 1'b0;
      sense_q  <= 1'b0;
      amp_en_q <= 1'b0;
    end
    else
    begin
      drive_q  <= (role_q == ROLE_MASTER); // RULE8
      sense_q  <= (role_q == ROLE_SLAVE); // RULE8
      amp_en_q <= (gain_q != GAIN_OFF) && (role_q != ROLE_SLAVE);
    end
  end

  assign GATE            = gate_q;
  assign PEAK_DIV        = div_q;
  assign SLOPE_DIV       = div_q; // RULE11
  assign AMP_GAIN        = gain_q;
  assign AMP_EN          = amp_en_q;
  assign COMP_DRIVE_EN   = drive_q;
  assign COMP_SENSE_ONLY = sense_q;
  assign FAIL_SAFE       = (mode_q == MD_FAILSAFE);

  assign LINK.phase_on            = gate_q | run;
  assign LINK.fail_safe_operation = (mode_q == MD_FAILSAFE);
  assign LINK.overvoltage         = ov_q;

endmodule : mbpc_device

// ### rtl/mbpc_host.sv
module mbpc_host
  import mbpc_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        NRST,
  mbpc_if.ctl              LINK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  import mbpc_pkg::*;

  // ***********************************************************
  // apb registers
  // ***********************************************************
  logic [7:0] ctrl_q;
  logic [7:0] amp_q;
  logic [7:0] share0_q;
  logic [7:0] share1_q;
  logic [7:0] share2_q;
  logic [7:0] ovthr_q;
  logic       wr;
  logic       mapped;

  assign wr     = PSEL && PENABLE && PWRITE;
  assign mapped = (PADDR == OFS_CTRL)   || (PADDR == OFS_AMP)    ||
                  (PADDR == OFS_SHARE0) || (PADDR == OFS_SHARE1) ||
                  (PADDR == OFS_SHARE2) || (PADDR == OFS_OVTHR)  ||
                  (PADDR == OFS_STATUS);

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_q   <= RST_CTRL;
      amp_q    <= RST_AMP;
      share0_q <= RST_SHARE;
      share1_q <= RST_SHARE;
      share2_q <= RST_SHARE;
      ovthr_q  <= RST_OVTHR;
    end
    else if (wr)
    begin
      case (PADDR)
        OFS_CTRL:   ctrl_q   <= PWDATA[7:0];
        OFS_AMP:    amp_q    <= PWDATA[7:0];
        OFS_SHARE0: share0_q <= PWDATA[7:0];
        OFS_SHARE1: share1_q <= PWDATA[7:0];
        OFS_SHARE2: share2_q <= PWDATA[7:0];
        OFS_OVTHR:  ovthr_q  <= PWDATA[7:0];
        default:    ctrl_q   <= ctrl_q;
      endcase
    end
  end

  logic [7:0] status;

  assign status = {3'h0, LINK.overvoltage, LINK.fail_safe_operation,
                   LINK.phase_on};

  always_comb
  begin
    case (PADDR)
      OFS_CTRL:   PRDATA = {24'h0, ctrl_q};
      OFS_AMP:    PRDATA = {24'h0, amp_q};
      OFS_SHARE0: PRDATA = {24'h0, 3'h0, share0_q[4:0]};
      OFS_SHARE1: PRDATA = {24'h0, 3'h0, share1_q[4:0]};
      OFS_SHARE2: PRDATA = {24'h0, 3'h0, share2_q[4:0]};
      OFS_OVTHR:  PRDATA = {24'h0, ovthr_q};
      OFS_STATUS: PRDATA = {24'h0, status};
      default:    PRDATA = 32'h0;
    endcase
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ***********************************************************
  // settings towards the device
  // ***********************************************************
  logic [1:0]        role;
  logic [1:0]        gain;
  logic [PHASES-1:0] en;

  assign role = amp_q[AMP_ROLE0 +: 2];
  assign gain = amp_q[AMP_GAIN0 +: 2];
  assign en   = ctrl_q[CTRL_EN0 +: PHASES];

  always_comb
  begin
    if (role == ROLE_SLAVE)
    begin
      LINK.sync_edge_invert = 1'b1; // RULE6
    end
    else if (role == ROLE_MASTER)
    begin
      LINK.sync_edge_invert = 1'b0; // RULE6
    end
    else
    begin
      LINK.sync_edge_invert = ctrl_q[CTRL_INV];
    end
  end

  always_comb
  begin
    if (role == ROLE_SLAVE)
    begin
      LINK.error_amp_gain = GAIN_OFF; // RULE7
    end
    else if (en == '0)
    begin
      LINK.error_amp_gain = GAIN_OFF; // RULE5
    end
    else
    begin
      LINK.error_amp_gain = gain;
    end
  end

  assign LINK.pin_function_select  = ctrl_q[CTRL_SEL];
  assign LINK.phase_enable_bit     = en;
  assign LINK.multiphase_role      = role;
  assign LINK.phase_power_share[0] = share0_q[SHARE_W-1:0];
  assign LINK.phase_power_share[1] = share1_q[SHARE_W-1:0];
  assign LINK.phase_power_share[2] = share2_q[SHARE_W-1:0];
  assign LINK.ov_threshold         = ovthr_q; // RULE13

endmodule : mbpc_host

// ### rtl/mbpc_if.sv
interface mbpc_if;
  import mbpc_pkg::*;

  logic                            pin_function_select;
  logic [PHASES-1:0]               phase_enable_bit;
  logic                            sync_edge_invert;
  logic [1:0]                      error_amp_gain;
  logic [1:0]                      multiphase_role;
  logic [PHASES-1:0][SHARE_W-1:0]  phase_power_share;
  logic [OV_W-1:0]                 ov_threshold;
  logic [PHASES-1:0]               phase_on;
  logic                            fail_safe_operation;
  logic                            overvoltage;

  modport dev (
    input  pin_function_select, phase_enable_bit, sync_edge_invert,
           error_amp_gain, multiphase_role, phase_power_share,
           ov_threshold,
    output phase_on, fail_safe_operation, overvoltage
  );

  modport ctl (
    output pin_function_select, phase_enable_bit, sync_edge_invert,
           error_amp_gain, multiphase_role, phase_power_share,
           ov_threshold,
    input  phase_on, fail_safe_operation, overvoltage
  );

endinterface : mbpc_if

// ### rtl/mbpc_pkg.sv
package mbpc_pkg;

  // ***********************************************************
  // widths and counts
  // ***********************************************************
  localparam int unsigned PHASES     = 3;
  localparam int unsigned SHARE_W    = 5;
  localparam int unsigned DIV_W      = 12;
  localparam int unsigned OV_W       = 8;
  localparam int unsigned SYNC_STAGES = 3;

  // ***********************************************************
  // pin positions in the synchroniser vector
  // ***********************************************************
  localparam int unsigned PIN_EN0    = 0;
  localparam int unsigned PIN_SHARED = 1;
  localparam int unsigned PIN_EN2    = 2;
  localparam int unsigned PIN_SYNC   = 3;
  localparam int unsigned PIN_TRIP0  = 4;
  localparam int unsigned PIN_CNT    = 7;

  // ***********************************************************
  // codes
  // ***********************************************************
  localparam logic [1:0] ROLE_MASTER = 2'h1;
  localparam logic [1:0] ROLE_SLAVE  = 2'h2;
  localparam logic [1:0] GAIN_OFF    = 2'h0;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_AMP   = 8'h00;
  localparam logic [7:0] RST_SHARE = 8'h00;
  localparam logic [7:0] RST_OVTHR = 8'hff;

  // ***********************************************************
  // controller apb map (byte addresses)
  // ***********************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_AMP    = 8'h04;
  localparam logic [7:0] OFS_SHARE0 = 8'h08;
  localparam logic [7:0] OFS_SHARE1 = 8'h0c;
  localparam logic [7:0] OFS_SHARE2 = 8'h10;
  localparam logic [7:0] OFS_OVTHR  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ctrl fields
  localparam int unsigned CTRL_SEL  = 0;
  localparam int unsigned CTRL_EN0  = 1;
  localparam int unsigned CTRL_INV  = 4;
  // amp fields
  localparam int unsigned AMP_GAIN0 = 0;
  localparam int unsigned AMP_ROLE0 = 2;

  // ***********************************************************
  // divider ratio in hundredths, indexed by raw share code
  // ***********************************************************
  localparam logic [DIV_W-1:0] DIV_TABLE [32] = '{
    12'h2a9, 12'h2c9, 12'h2eb, 12'h311, 12'h33b, 12'h369, 12'h39d, 12'h3d8,
    12'h41b, 12'h467, 12'h4c0, 12'h527, 12'h5a2, 12'h636, 12'h6eb, 12'h7d0,
    12'h190, 12'h19b, 12'h1a6, 12'h1b2, 12'h1be, 12'h1cb, 12'h1d9, 12'h1e8,
    12'h1f8, 12'h209, 12'h21b, 12'h22f, 12'h243, 12'h25a, 12'h272, 12'h28d
  };

  typedef enum logic [0:0] {MD_NORMAL, MD_FAILSAFE} mbpc_mode_t;

endpackage : mbpc_pkg

// ### tb/mbpc_assertions.sv
module mbpc_assertions
  import mbpc_pkg::*;
(
  input wire logic                        MCLK,
  input wire logic                        NRST,
  input wire logic                        pin_function_select,
  input wire logic [mbpc_pkg::PHASES-1:0] phase_enable_bit,
  input wire logic                        sync_edge_invert,
  input wire logic [1:0]                  error_amp_gain,
  input wire logic [1:0]                  multiphase_role,
  input wire logic [mbpc_pkg::PHASES-1:0] phase_on,
  input wire logic                        fail_safe_operation
);
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************************
  // link checks
  // ***********************************************************
  default clocking link_cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  fso_sticky_a: assert property (
    fail_safe_operation |=> fail_safe_operation)
    else $error("fail-safe flag dropped");

  fso_sel_a: assert property (
    pin_function_select [*3] |=> !$rose(fail_safe_operation))
    else $error("fail-safe entered with enable function");

  bit_rise_a: assert property (
    (!pin_function_select && $rose(phase_enable_bit[1]))
      |-> ##[1:6] phase_on[1])
    else $error("phase 1 not started by enable bit");

  bit0_off_a: assert property (
    !phase_enable_bit[0] [*6] |-> !phase_on[0])
    else $error("phase 0 on with enable bit low");

  bit2_off_a: assert property (
    !phase_enable_bit[2] [*6] |-> !phase_on[2])
    else $error("phase 2 on with enable bit low");

  all_off_gain_a: assert property (
    (phase_enable_bit == '0) |-> (error_amp_gain == GAIN_OFF))
    else $error("gain sent with all phases off");

  slave_inv_a: assert property (
    (multiphase_role == ROLE_SLAVE) |-> sync_edge_invert)
    else $error("slave without sync inversion");

  master_inv_a: assert property (
    (multiphase_role == ROLE_MASTER) |-> !sync_edge_invert)
    else $error("master with sync inversion");

  slave_gain_a: assert property (
    (multiphase_role == ROLE_SLAVE) |-> (error_amp_gain == GAIN_OFF))
    else $error("slave with amplifier gain");

endmodule : mbpc_assertions

// ### tb/test_multiphase_boost_phase_control.sv
module test_multiphase_boost_phase_control
  import mbpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ***********************************************************
  // signals
  // ***********************************************************
  logic                         mclk, nrst, psel, penable, pwrite;
  logic                         sync_in, pready, pslverr, er;
  logic                         amp_en, comp_drive_en, comp_sense_only;
  logic                         fail_safe;
  logic [1:0]                   amp_gain;
  logic [7:0]                   paddr, ov_sense;
  logic [31:0]                  pwdata, prdata, rdata;
  logic [PHASES-1:0]            enable_pin, peak_trip, gate;
  logic [PHASES-1:0][DIV_W-1:0] peak_div, slope_div;
  int                           err_count, n_compared, cycles;

  mbpc_if mbpc_if_i ();

  mbpc_device mbpc_device_i (
    .MCLK(mclk), .NRST(nrst), .LINK(mbpc_if_i),
    .ENABLE_PIN(enable_pin), .SYNC_IN(sync_in), .PEAK_TRIP(peak_trip),
    .OV_SENSE(ov_sense), .GATE(gate), .PEAK_DIV(peak_div),
    .SLOPE_DIV(slope_div), .AMP_GAIN(amp_gain), .AMP_EN(amp_en),
    .COMP_DRIVE_EN(comp_drive_en), .COMP_SENSE_ONLY(comp_sense_only),
    .FAIL_SAFE(fail_safe));

  mbpc_host mbpc_host_i (
    .MCLK(mclk), .NRST(nrst), .LINK(mbpc_if_i), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  mbpc_assertions mbpc_assertions_i (
    .MCLK(mclk), .NRST(nrst),
    .pin_function_select(mbpc_if_i.pin_function_select),
    .phase_enable_bit(mbpc_if_i.phase_enable_bit),
    .sync_edge_invert(mbpc_if_i.sync_edge_invert),
    .error_amp_gain(mbpc_if_i.error_amp_gain),
    .multiphase_role(mbpc_if_i.multiphase_role),
    .phase_on(mbpc_if_i.phase_on),
    .fail_safe_operation(mbpc_if_i.fail_safe_operation));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      conclude();
    end
  end

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdata = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rdc

  task automatic sy(input logic v);
    sync_in <= v;
    cyc(8);
  endtask : sy

  task automatic trip();
    peak_trip <= 3'b111;
    cyc(8);
    peak_trip <= 3'b000;
    cyc(4);
  endtask : trip

  function automatic logic [31:0] div_exp(input int raw);
    int sgn;
    sgn = (raw > 15) ? raw - 32 : raw;
    return 32'($rtoi(100.0 / (0.05 + real'(15 - sgn) / 155.0) + 0.5));
  endfunction : div_exp

  // ***********************************************************
  // sequence
  // ***********************************************************
  initial
  begin
    {nrst, psel, penable, pwrite, sync_in} = '0;
    {paddr, ov_sense, enable_pin, peak_trip} = '0;
    pwdata = '0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_AMP, 32'h0);
    rdc(OFS_SHARE2, 32'h0);
    rdc(OFS_OVTHR, 32'hff);
    apb(1'b0, 8'h1c, 32'h0);
    chk({rdata[30:0], er}, 32'h1);
    for (int c = 0; c < 32; c++)
    begin
      for (int i = 0; i < 3; i++)
        wr(8'(OFS_SHARE0 + 4 * i), 32'hffffffe0 | 32'((c + 11 * i) % 32));
      cyc(4);
      for (int i = 0; i < 3; i++)
      begin
        chk(32'(peak_div[i]), div_exp((c + 11 * i) % 32));
        chk(32'(slope_div[i]), div_exp((c + 11 * i) % 32));
      end
      rdc(OFS_SHARE1, 32'((c + 11) % 32));
    end
    wr(OFS_CTRL, 32'h02);
    for (int r = 0; r < 4; r++)
    begin
      wr(OFS_AMP, 32'(r * 4 + 3));
      cyc(4);
      chk(32'(amp_gain), (r == 2) ? 32'h0 : 32'h3);
      chk(32'({amp_en, comp_drive_en, comp_sense_only}),
          32'({r != 2, r == 1, r == 2}));
    end
    wr(OFS_CTRL, 32'h00);
    cyc(4);
    chk(32'({amp_gain, amp_en}), 32'h0);
    wr(OFS_AMP, 32'h0);
    enable_pin <= 3'b101;
    wr(OFS_CTRL, 32'h0f);
    cyc(8);
    rdc(OFS_STATUS, 32'h05);
    enable_pin <= 3'b111;
    wr(OFS_CTRL, 32'h0b);
    cyc(8);
    rdc(OFS_STATUS, 32'h05);
    wr(OFS_CTRL, 32'h0f);
    cyc(8);
    sync_in <= 1'b1;
    cyc(1);
    sy(1'b0);
    chk(32'(gate), 32'h0);
    sy(1'b1);
    chk(32'(gate), 32'h7);
    trip();
    chk(32'(gate), 32'h0);
    sy(1'b0);
    chk(32'(gate), 32'h0);
    wr(OFS_CTRL, 32'h1f);
    trip();
    sy(1'b1);
    chk(32'(gate), 32'h0);
    sy(1'b0);
    chk(32'(gate), 32'h7);
    wr(OFS_OVTHR, 32'h80);
    ov_sense <= 8'h81;
    cyc(6);
    chk(32'(gate), 32'h0);
    rdc(OFS_STATUS, 32'h17);
    ov_sense <= 8'h80;
    sy(1'b1);
    sy(1'b0);
    chk(32'(gate), 32'h7);
    wr(OFS_CTRL, 32'h1d);
    trip();
    sy(1'b1);
    sy(1'b0);
    chk(32'(gate), 32'h6);
    rdc(OFS_STATUS, 32'h06);
    wr(OFS_CTRL, 32'h01);
    cyc(8);
    enable_pin <= 3'b101;
    cyc(8);
    chk(32'(fail_safe), 32'h0);
    wr(OFS_CTRL, 32'h00);
    enable_pin <= 3'b111;
    cyc(8);
    enable_pin <= 3'b000;
    cyc(8);
    chk(32'(fail_safe), 32'h1);
    wr(OFS_CTRL, 32'h0e);
    cyc(8);
    rdc(OFS_STATUS, 32'h0f);
    wr(OFS_CTRL, 32'h04);
    cyc(8);
    rdc(OFS_STATUS, 32'h0a);
    nrst <= 1'b0;
    cyc(2);
    chk(32'({fail_safe, gate}), 32'h0);
    nrst <= 1'b1;
    cyc(4);
    rdc(OFS_STATUS, 32'h00);
    chk(32'(peak_div[0]), div_exp(0));
    conclude();
  end

endmodule : test_multiphase_boost_phase_control
